// ### bench/power_domain_crossing_bridge_tb_top.sv
// Self-checking bench for the power domain crossing bridge
`default_nettype none
module power_domain_crossing_bridge_tb_top
   import pdc_bridge_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, mclk, mrst, valid, pdn, done, ready, rvalid, ack, m_req;
   bus_req_t req, m_data;
   bus_rsp_t rsp, m_rsp;
   logic [4:0] dly; // Target answer delay, prompt or slow
   int errors, cmp_count, cycles;
   int fwd_count; // Transfers the target actually completed
   power_domain_crossing_bridge dut (.i_sys_clk(clk), .i_rst(rst),
      .i_mst_clk(mclk), .i_mst_rst(mrst), .i_s_valid(valid),
      .o_s_ready(ready), .i_s_req(req), .o_s_rvalid(rvalid), .o_s_rsp(rsp),
      .i_pdn_req(pdn), .o_pdn_ack(ack), .o_m_req(m_req), .o_m_data(m_data),
      .i_m_done(done), .i_m_rsp(m_rsp));
   target_model tgt (.i_clk(mclk), .i_rst(mrst), .i_req(m_req),
      .i_data(m_data), .i_dly(dly), .o_done(done), .o_rsp(m_rsp));
   // Master clock unrelated in rate and phase
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      mclk = 1'b0;
      #1.3;
      forever #3.5 mclk = ~mclk;
   end
   task give_verdict();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         $display("MISMATCH %0t %s", $time, m);
         errors++;
      end
   endtask
   // Hold request until ready, taken at the next edge
   task send(input logic w, input logic [31:0] a);
      valid = 1'b1;
      req = '{wr: w, addr: a, wdata: ~a};
      while (ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      valid = 1'b0;
   endtask
   // Follow one forwarded transaction to its answer
   task await_ok(input logic w, input logic [31:0] a);
      logic seen;
      bus_req_t fwd; // What the target must receive
      bus_rsp_t good; // What the requester must get back
      seen = 1'b0;
      fwd = '{wr: w, addr: a, wdata: ~a};
      good = '{resp: RESP_OKAY, rdata: ~a};
      for (int n = 0; n < 80 && !seen; n++)
      begin
         if (m_req === 1'b1)
            chk(m_data === fwd, "forwarded request");
         seen = (rvalid === 1'b1);
         if (!seen && !pdn)
            chk(ready === 1'b0, "ready while open");
         if (!seen)
            chk(ack === 1'b0, "ack while open");
         if (!seen)
            @(posedge clk) #1;
      end
      chk(seen && rsp === good, "normal answer");
      @(posedge clk) #1;
      chk(rvalid === 1'b0 && ready === 1'b1, "answer not single");
   endtask
   // Back-to-back requests under a pending power-down
   task reject(input int k);
      valid = 1'b1;
      for (int n = 0; n < k; n++)
      begin
         req = '{wr: n[0], addr: 32'h0000_0100 + n, wdata: DATA_RST};
         @(posedge clk) #1;
         chk(rvalid === 1'b1 && rsp.resp === RESP_SLVERR, "reject");
         chk(rsp.rdata === DATA_RST, "reject data");
         chk(ready === 1'b1, "requester stalled");
      end
      valid = 1'b0;
      // Last answer is still up here; one answer per request only
      @(posedge clk) #1;
      chk(rvalid === 1'b0, "extra answer");
   endtask
   task wait_ack(input logic lvl);
      for (int n = 0; n < 10 && ack !== lvl; n++) @(posedge clk) #1;
      chk(ack === lvl, "ack level");
   endtask
   task t_normal();
      dly = 5'h00;
      send(1'b1, 32'h1234_5678);
      await_ok(1'b1, 32'h1234_5678);
      dly = 5'h09;
      send(1'b0, 32'hA5A5_0F0F);
      await_ok(1'b0, 32'hA5A5_0F0F);
   endtask
   task t_pdn_idle();
      pdn = 1'b1;
      wait_ack(1'b1);
      reject(4);
      chk(ack === 1'b1, "ack dropped");
      pdn = 1'b0;
      wait_ack(1'b0);
      send(1'b0, 32'h0000_0040);
      await_ok(1'b0, 32'h0000_0040);
   endtask
   task t_pdn_open();
      dly = 5'h14;
      send(1'b1, 32'h8000_0004);
      pdn = 1'b1;
      repeat (6) @(posedge clk) #1;
      reject(2);
      await_ok(1'b1, 32'h8000_0004);
      wait_ack(1'b1);
      pdn = 1'b0;
      wait_ack(1'b0);
   endtask
   // Master half shut down only after the bridge reports idle
   task t_mst_reset();
      pdn = 1'b1;
      wait_ack(1'b1);
      mrst = 1'b1;
      repeat (4) @(posedge clk) #1;
      chk(ready === 1'b1 && rvalid === 1'b0, "slave half disturbed");
      chk(ack === 1'b1, "ack lost in master reset");
      mrst = 1'b0;
      pdn = 1'b0;
      wait_ack(1'b0);
      send(1'b1, 32'h0000_0FF0);
      await_ok(1'b1, 32'h0000_0FF0);
   endtask
   // Count target handshakes; rejected requests must never get there
   always @(posedge mclk)
   begin
      if (m_req === 1'b1 && done === 1'b1)
         fwd_count++;
   end
   // Hang guard well above the expected run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict();
      end
   end
   initial
   begin
      {rst, mrst, valid, pdn} = 4'hC;
      req = REQ_RST;
      dly = 5'h00;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      mrst = 1'b0;
      t_normal();
      t_pdn_idle();
      t_pdn_open();
      t_mst_reset();
      // Five accepted transfers in all; every reject stayed local
      chk(fwd_count == 5, "forwarded count");
      give_verdict();
   end
endmodule // power_domain_crossing_bridge_tb_top
`default_nettype wire

// ### bench/target_model.sv
// Behavioural target on the master half of the bridge
`default_nettype none
module target_model
   import pdc_bridge_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire bus_req_t i_data,
   input wire logic [4:0] i_dly,
   output logic o_done,
   output bus_rsp_t o_rsp
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] wait_r; // Cycles spent on the open request
   // Answer after i_dly cycles; rsp scrambled outside done so stale
   // data never looks valid
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wait_r <= 5'h00;
         o_done <= 1'b0;
         o_rsp <= RSP_RST;
      end
      else if (i_req && !o_done && wait_r == i_dly)
      begin
         o_done <= 1'b1;
         o_rsp <= '{resp: RESP_OKAY, rdata: ~i_data.addr};
      end
      else
      begin
         // Count only while a request waits
         wait_r <= (i_req && !o_done) ? wait_r + 5'h01 : 5'h00;
         o_done <= 1'b0;
         o_rsp <= ~o_rsp;
      end
   end
endmodule // target_model
`default_nettype wire

// ### pkg/pdc_bridge_pkg.sv
// Shared types and constants for the power domain crossing bridge
`default_nettype none
package pdc_bridge_pkg;
   // Bus response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Outstanding transaction counter
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
   // Bus widths
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

   // Request carried from slave half to master half
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   // Response carried back from master half to slave half
   typedef struct packed {
      logic [1:0] resp;
      logic [DATA_W-1:0] rdata;
   } bus_rsp_t;

   localparam bus_req_t REQ_RST = '{wr: 1'b0, addr: 32'h0000_0000,
                                    wdata: 32'h0000_0000};
   localparam bus_rsp_t RSP_RST = '{resp: RESP_OKAY, rdata: 32'h0000_0000};
endpackage
`default_nettype wire

// ### verilog/power_domain_crossing_bridge.sv
// Split bus bridge joining two asynchronous power and clock domains
//
// Summary of operation
// [R1] Slave half and master half, one domain each
// [R2] Each half has own clock and reset
// [R3] Crossing synchronizer split across both domains
// [R4] Power boundary sits at clock crossing
// [R5] Count open transactions, capture power-down request
// [R6] Pending power-down: new errored, open complete
// [R7] Count zero under request: acknowledge shutdown
// [R8] Interconnect off only when all bridges idle
// [R9] Rejected transactions get slave error, handshake completes
// [R10] Acknowledge holds until request withdrawn, then resume
`default_nettype none
module power_domain_crossing_bridge
   import pdc_bridge_pkg::*;
(
   // Slave half domain
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Master half domain
   input wire logic i_mst_clk,
   input wire logic i_mst_rst,
   // Requester side (slave half)
   input wire logic i_s_valid,
   output logic o_s_ready,
   input wire bus_req_t i_s_req,
   output logic o_s_rvalid,
   output bus_rsp_t o_s_rsp,
   // Platform manager handshake (slave half)
   input wire logic i_pdn_req,
   output logic o_pdn_ack,
   // Target side (master half)
   output logic o_m_req,
   output bus_req_t o_m_data,
   input wire logic i_m_done,
   input wire bus_rsp_t i_m_rsp
);

   // [R1] slave half, wholly in i_sys_clk domain
   logic pdn_s1_r; // First sync stage, read only by second
   logic pdn_s2_r; // Synchronised request level
   logic pend_r; // Logged power-down request
   logic [CNT_W-1:0] cnt_r; // Open transactions
   logic req_tgl_r; // Launch event toward master half
   bus_req_t req_hold_r; // Payload, stable while open
   logic rsp_s1_r; // First sync stage of response toggle
   logic rsp_s2_r;
   logic rsp_s3_r; // Edge reference
   logic rsp_evt; // Response arrived from master half
   logic accept; // Request taken this cycle
   logic cnt_zero;

   // [R1] master half, wholly in i_mst_clk domain
   logic req_s1_r; // First sync stage of launch toggle
   logic req_s2_r;
   logic req_s3_r;
   logic req_evt;
   logic rsp_tgl_r; // Completion event toward slave half
   bus_rsp_t rsp_hold_r; // Response, stable until next completion

   assign rsp_evt = rsp_s2_r ^ rsp_s3_r;
   assign cnt_zero = (cnt_r == CNT_ZERO);
   // [R9] idle or shutting down: do not stall a request
   // While shutting down, refuse only in the cycle a response lands,
   // since the answer port carries one response per cycle.
   assign o_s_ready = cnt_zero | (pend_r & ~rsp_evt);
   assign accept = i_s_valid & o_s_ready;

   // Power-down request synchroniser
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pdn_s1_r <= 1'b0;
         pdn_s2_r <= 1'b0;
      end
      else
      begin
         pdn_s1_r <= i_pdn_req;
         pdn_s2_r <= pdn_s1_r;
      end
   end

   // [R5] log power-down request
   // Held for as long as the manager keeps its level up
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         pend_r <= 1'b0;
      else
         pend_r <= pdn_s2_r;
   end

   // [R5] open transaction counter
   // Ready excludes a launch while busy, so no up and down together
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         cnt_r <= CNT_ZERO;
      else if (accept & ~pend_r)
         cnt_r <= cnt_r + CNT_ONE;
      else if (rsp_evt)
         cnt_r <= cnt_r - CNT_ONE;
   end

   // [R3] slave part of crossing: launch
   // Payload is held until the response comes back, so the master
   // half may sample it safely after its toggle synchroniser.
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         req_tgl_r <= 1'b0;
         req_hold_r <= REQ_RST;
      end
      else if (accept & ~pend_r)
      begin
         req_tgl_r <= ~req_tgl_r;
         req_hold_r <= i_s_req;
      end
   end

   // [R3] slave part of crossing: response toggle sync
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rsp_s1_r <= 1'b0;
         rsp_s2_r <= 1'b0;
         rsp_s3_r <= 1'b0;
      end
      else
      begin
         rsp_s1_r <= rsp_tgl_r;
         rsp_s2_r <= rsp_s1_r;
         rsp_s3_r <= rsp_s2_r;
      end
   end

   // Answer to requester, one-cycle pulse
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_s_rvalid <= 1'b0;
         o_s_rsp <= RSP_RST;
      end
      else if (accept & pend_r)
      begin
         // [R6] reject new transaction
         // [R9] slave error with handshake
         o_s_rvalid <= 1'b1;
         o_s_rsp <= '{resp: RESP_SLVERR, rdata: DATA_RST};
      end
      else if (rsp_evt)
      begin
         // [R6] open transaction completes normally
         o_s_rvalid <= 1'b1;
         o_s_rsp <= rsp_hold_r;
      end
      else
         o_s_rvalid <= 1'b0;
   end

   // [R7] acknowledge when drained
   // [R10] drop ack once request withdrawn
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_pdn_ack <= 1'b0;
      else
         o_pdn_ack <= pend_r & pdn_s2_r & cnt_zero;
   end

   // [R4] master half below lives wholly in i_mst_clk domain
   // [R3] master part of crossing: launch toggle sync
   assign req_evt = req_s2_r ^ req_s3_r;
   always_ff @(posedge i_mst_clk or posedge i_mst_rst)
   begin
      if (i_mst_rst)
      begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end
      else
      begin
         req_s1_r <= req_tgl_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end

   // [R2] master request issue on own clock and reset
   always_ff @(posedge i_mst_clk or posedge i_mst_rst)
   begin
      if (i_mst_rst)
      begin
         o_m_req <= 1'b0;
         o_m_data <= REQ_RST;
      end
      else if (req_evt)
      begin
         o_m_req <= 1'b1;
         o_m_data <= req_hold_r;
      end
      else if (i_m_done)
         o_m_req <= 1'b0;
   end

   // Completion returned toward slave half
   always_ff @(posedge i_mst_clk or posedge i_mst_rst)
   begin
      if (i_mst_rst)
      begin
         rsp_tgl_r <= 1'b0;
         rsp_hold_r <= RSP_RST;
      end
      else if (o_m_req & i_m_done)
      begin
         rsp_tgl_r <= ~rsp_tgl_r;
         rsp_hold_r <= i_m_rsp;
      end
   end

   // Checks, slave half; each names its clock, as two domains live here
   sequence s_reject;
      accept && pend_r;
   endsequence
   sequence s_err_answer;
      o_s_rvalid && (o_s_rsp.resp == RESP_SLVERR);
   endsequence

   chk_err_new_txn: // [R6]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         s_reject |=> s_err_answer)
      else $error("new transaction under power-down not errored");
   chk_no_stall: // [R9]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         i_s_valid && pend_r && !rsp_evt |=> o_s_rvalid)
      else $error("requester stalled during power-down");
   chk_cnt_up: // [R5]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         accept && !pend_r |=> cnt_r == CNT_ONE)
      else $error("open count not raised on launch");
   chk_pdn_logged: // [R5]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         i_pdn_req [*3] |=> pend_r)
      else $error("power-down request not logged");
   chk_ack_drained: // [R7]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         (pend_r && cnt_zero) ##1 pend_r |-> o_pdn_ack)
      else $error("no acknowledge with zero open transactions");
   chk_ack_cause: // [R7]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         o_pdn_ack |-> $past(cnt_zero) && $past(pend_r))
      else $error("acknowledge while transactions open");
   chk_ack_release: // [R10]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         !pdn_s2_r |=> !o_pdn_ack ##1 !o_pdn_ack)
      else $error("acknowledge held after request withdrawn");
   chk_resume: // [R10]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         !pend_r && accept |=> cnt_r == CNT_ONE ##0 !o_s_rvalid)
      else $error("normal traffic not resumed");
   chk_rsp_return: // [R6]
      assert property (@(posedge i_sys_clk) disable iff (i_rst)
         rsp_evt |=> o_s_rvalid && o_s_rsp == $past(rsp_hold_r))
      else $error("open transaction response lost");

   // Checks, master half
   chk_m_launch: // [R3]
      assert property (@(posedge i_mst_clk) disable iff (i_mst_rst)
         req_evt |=> o_m_req && o_m_data == $past(req_hold_r))
      else $error("crossed request not issued");

endmodule // power_domain_crossing_bridge
`default_nettype wire
